// >>> hbf_defines.svh
// Timing counts, register offsets and field positions for the supervisor.
// Assumes a 25 MHz system clock; all counts are derived from it.
`ifndef HBF_DEFINES_SVH
`define HBF_DEFINES_SVH
// ==========================================================================
// Timing
`define HBF_CLK_MHZ        25
`define HBF_T_SET_US       10
`define HBF_T_SET_CYC      (`HBF_T_SET_US * `HBF_CLK_MHZ)
`define HBF_T_OC_NS        5000
`define HBF_T_OC_CYC       ((`HBF_T_OC_NS * `HBF_CLK_MHZ + 999) / 1000)
`define HBF_T_OL_NS        100000
`define HBF_T_OL_CYC       ((`HBF_T_OL_NS * `HBF_CLK_MHZ + 999) / 1000)
`define HBF_T_OLS_NS       20000
`define HBF_T_OLS_CYC      ((`HBF_T_OLS_NS * `HBF_CLK_MHZ + 999) / 1000)
`define HBF_DEAD_TIME_HIGH_TO_LOW_NS       2000
`define HBF_DEAD_TIME_HIGH_TO_LOW_CYC      ((`HBF_DEAD_TIME_HIGH_TO_LOW_NS * `HBF_CLK_MHZ + 999) / 1000)
`define HBF_DEAD_TIME_LOW_TO_HIGH_NS       2000
`define HBF_DEAD_TIME_LOW_TO_HIGH_CYC      ((`HBF_DEAD_TIME_LOW_TO_HIGH_NS * `HBF_CLK_MHZ + 999) / 1000)
// ==========================================================================
// Frame and registers
`define HBF_FRAME_BITS     16
`define HBF_A_HS_EN        7'h00
`define HBF_A_LS_EN        7'h01
`define HBF_A_FWOL         7'h02
`define HBF_A_GSTAT        7'h10
`define HBF_A_HS_OC        7'h11
`define HBF_A_LS_OC        7'h12
`define HBF_A_HS_OL        7'h13
`define HBF_A_LS_OL        7'h14
`define HBF_G_LE           6
`define HBF_G_UV           5
`define HBF_G_OV           4
`define HBF_G_POWER_ON_RESET_NEGATED         3
`define HBF_G_TSD          2
`define HBF_G_TPW          1
`endif

// >>> hbf_pkg.sv
// Types shared by the supervisor.
// Assumes hbf_defines.svh holds all numbers.
package hbf_pkg;
  typedef enum logic [0:0] {
    HBF_IDLE  = 1'b0,
    HBF_SHIFT = 1'b1
  } hbf_spi_state_t;

  typedef struct packed {
    logic warn;
    logic sd;
    logic uv;
    logic ov;
  } hbf_supply_t;

  typedef struct packed {
    logic       op;
    logic [6:0] addr;
    logic [7:0] data;
  } hbf_frame_t;
endpackage : hbf_pkg

// >>> hbf_supervisor.sv
// Fault supervisor and serial port for an eight-channel half-bridge driver.
// Assumes analog comparators on the raw inputs and a host SPI master.
// How it works
// - Overcurrent drops switch, keeps enable, sets flags
// - Latch off after full filter; hold while flagged
// - Clearing overcurrent flag re-arms enabled switch
// - Never both sides on; dead time between
// - Prewarning latches, outputs stay active
// - Shutdown latches all outputs off until cleared
// - Clearing shutdown resumes; persisting fault re-sets
// - Undervoltage: outputs off, flag latched, auto-recover
// - Overvoltage: outputs off, flag latched, auto-recover
// - Logic reset: port dead, state cleared, high-Z
// - Reset event shows as power-on bit zero
// - Open load after filter latches flags, output on
// - First two high sides: selectable low threshold
// - Free-wheeling stages blank open-load detection
// - Sixteen-bit frame starts on chip-select fall
// - Sample on falling clock, shift on rising
// - Act at chip-select rise; release data out
// - Addressed register returns within same frame
// - Byte-wide access; device never self-clears
// - Ignore frames too soon after enable rise
// - Operation bit one clears status, zero reads
`include "hbf_defines.svh"
`timescale 1ns/1ps
module hbf_supervisor
  import hbf_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        sclk_i,
  input  wire logic        csn_i,
  input  wire logic        sdi_i,
  input  wire logic        en_i,
  input  wire hbf_supply_t supply_i,
  input  wire logic [15:0] oc_raw_i,
  input  wire logic [15:0] ol_raw_i,
  input  wire logic [15:0] fw_active_i,
  output logic      [7:0]  hs_on_o,
  output logic      [7:0]  ls_on_o,
  output logic      [1:0]  ol_low_thr_o,
  output logic             sdo_o,
  output logic             sdo_oe_o
);
  // ========================================================================
  // Input synchronisers
  logic [39:0]    sy1_reg, sy2_reg;
  logic           sclk_d_reg, csn_d_reg;
  logic           sclk_s, csn_s, sdi_s, en_s;
  hbf_supply_t    sup_s;
  logic [15:0]    oc_s, ol_s;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_reg    <= 40'h40_0000_0000; // Chip select idles high: no false fall
      sy2_reg    <= 40'h40_0000_0000;
      sclk_d_reg <= 1'b0;
      csn_d_reg  <= 1'b1;
    end else begin
      sy1_reg    <= {sclk_i, csn_i, sdi_i, en_i, supply_i, oc_raw_i, ol_raw_i};
      sy2_reg    <= sy1_reg;
      sclk_d_reg <= sy2_reg[39];
      csn_d_reg  <= sy2_reg[38];
    end
  end

  assign sclk_s = sy2_reg[39];
  assign csn_s  = sy2_reg[38];
  assign sdi_s  = sy2_reg[37];
  assign en_s   = sy2_reg[36];
  assign sup_s  = hbf_supply_t'(sy2_reg[35:32]);
  assign oc_s   = sy2_reg[31:16];
  assign ol_s   = sy2_reg[15:0];

  // ========================================================================
  // Enable setup window
  logic [8:0] set_cnt_reg;
  logic       set_done;
  assign set_done = (set_cnt_reg == 9'(`HBF_T_SET_CYC));

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      set_cnt_reg <= 9'h0;
    end else if (!en_s) begin
      set_cnt_reg <= 9'h0;
    end else if (!set_done) begin
      set_cnt_reg <= set_cnt_reg + 9'h1;
    end
  end

  // ========================================================================
  // Serial port
  hbf_spi_state_t state_reg;
  logic [4:0]     cnt_reg;
  logic [15:0]    rx_reg;
  logic [7:0]     addr_reg;
  logic           go_reg;
  hbf_frame_t     cmd_reg;
  logic [7:0]     gstat, rd_data;
  logic           out_bit;
  logic           csn_fall, csn_rise, sclk_fall, sclk_rise;

  assign csn_fall  = csn_d_reg & ~csn_s;
  assign csn_rise  = ~csn_d_reg & csn_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s;
  assign out_bit   = (cnt_reg < 5'd8) ? gstat[3'd7 - cnt_reg[2:0]]
                                      : rd_data[3'd7 - cnt_reg[2:0]];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= HBF_IDLE;
      cnt_reg   <= 5'h0;
      rx_reg    <= 16'h0;
      addr_reg  <= 8'h0;
      go_reg    <= 1'b0;
      cmd_reg   <= '0;
      sdo_o     <= 1'b0;
      sdo_oe_o  <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      case (state_reg)
        HBF_IDLE: begin
          if (csn_fall && set_done) begin
            state_reg <= HBF_SHIFT;
            cnt_reg   <= 5'h0;
            sdo_oe_o  <= 1'b1;
            sdo_o     <= gstat[7];
          end
        end
        HBF_SHIFT: begin
          if (csn_rise) begin
            state_reg <= HBF_IDLE;
            sdo_oe_o  <= 1'b0;
            go_reg    <= (cnt_reg == 5'(`HBF_FRAME_BITS));
            cmd_reg   <= {addr_reg, rx_reg[7:0]};
          end else if (sclk_fall) begin
            rx_reg <= {rx_reg[14:0], sdi_s};
            if (cnt_reg == 5'd7) begin
              addr_reg <= {rx_reg[6:0], sdi_s};
            end
            if (cnt_reg != 5'h1f) begin
              cnt_reg <= cnt_reg + 5'h1;
            end
          end else if (sclk_rise && cnt_reg < 5'(`HBF_FRAME_BITS)) begin
            sdo_o <= out_bit;
          end
        end
        default: state_reg <= HBF_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Control registers
  logic [7:0] hs_en_reg, ls_en_reg;
  logic [1:0] fwol_reg;
  logic       wr;
  assign wr = go_reg & cmd_reg.op;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hs_en_reg <= 8'h0;
      ls_en_reg <= 8'h0;
      fwol_reg  <= 2'h0;
    end else if (wr) begin
      if (cmd_reg.addr == `HBF_A_HS_EN) begin
        hs_en_reg <= cmd_reg.data;
      end else if (cmd_reg.addr == `HBF_A_LS_EN) begin
        ls_en_reg <= cmd_reg.data;
      end else if (cmd_reg.addr == `HBF_A_FWOL) begin
        fwol_reg <= cmd_reg.data[1:0];
      end
    end
  end

  // ========================================================================
  // Status flags; a set in the clear cycle wins
  logic [15:0] oc_flag, ol_flag, oc_set, ol_set, oc_clr, ol_clr;
  logic        le_reg, uv_reg, ov_reg, tsd_reg, tpw_reg, power_on_reset_negated_reg, gclr;

  always_comb begin
    oc_clr = 16'h0;
    ol_clr = 16'h0;
    gclr   = 1'b0;
    if (wr && cmd_reg.addr == `HBF_A_HS_OC) begin
      oc_clr[7:0] = 8'hff;
    end else if (wr && cmd_reg.addr == `HBF_A_LS_OC) begin
      oc_clr[15:8] = 8'hff;
    end else if (wr && cmd_reg.addr == `HBF_A_HS_OL) begin
      ol_clr[7:0] = 8'hff;
    end else if (wr && cmd_reg.addr == `HBF_A_LS_OL) begin
      ol_clr[15:8] = 8'hff;
    end else if (wr && cmd_reg.addr == `HBF_A_GSTAT) begin
      gclr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      le_reg   <= 1'b0;
      uv_reg   <= 1'b0;
      ov_reg   <= 1'b0;
      tsd_reg  <= 1'b0;
      tpw_reg  <= 1'b0;
      power_on_reset_negated_reg <= 1'b0;
    end else begin
      le_reg   <= (|oc_set) | (|ol_set) | (le_reg & ~gclr);
      uv_reg   <= sup_s.uv | (uv_reg & ~gclr);
      ov_reg   <= sup_s.ov | (ov_reg & ~gclr);
      tsd_reg  <= sup_s.sd | (tsd_reg & ~gclr);
      tpw_reg  <= sup_s.warn | (tpw_reg & ~gclr);
      power_on_reset_negated_reg <= power_on_reset_negated_reg | gclr;
    end
  end

  assign gstat = {1'b0, le_reg, uv_reg, ov_reg, power_on_reset_negated_reg, tsd_reg,
                  tpw_reg, 1'b0};

  always_comb begin
    if (addr_reg[6:0] == `HBF_A_HS_EN) begin
      rd_data = hs_en_reg;
    end else if (addr_reg[6:0] == `HBF_A_LS_EN) begin
      rd_data = ls_en_reg;
    end else if (addr_reg[6:0] == `HBF_A_FWOL) begin
      rd_data = {6'h0, fwol_reg};
    end else if (addr_reg[6:0] == `HBF_A_GSTAT) begin
      rd_data = gstat;
    end else if (addr_reg[6:0] == `HBF_A_HS_OC) begin
      rd_data = oc_flag[7:0];
    end else if (addr_reg[6:0] == `HBF_A_LS_OC) begin
      rd_data = oc_flag[15:8];
    end else if (addr_reg[6:0] == `HBF_A_HS_OL) begin
      rd_data = ol_flag[7:0];
    end else if (addr_reg[6:0] == `HBF_A_LS_OL) begin
      rd_data = ol_flag[15:8];
    end else begin
      rd_data = 8'h0;
    end
  end

  // ========================================================================
  // Per-switch filters; index 0..7 high sides, 8..15 low sides
  logic [15:0] sw_on, allow;
  assign sw_on = {ls_on_o, hs_on_o};
  assign allow = {ls_en_reg, hs_en_reg} & ~oc_flag
               & {16{~(tsd_reg | sup_s.sd | sup_s.uv | sup_s.ov)}};

  for (genvar i = 0; i < 16; i++) begin : g_sw
    logic [11:0] oc_cnt_reg, ol_cnt_reg, ol_lim;
    logic        oc_q, ol_q, oc_cond, ol_cond;
    assign oc_cond = oc_s[i] & sw_on[i];
    assign ol_cond = ol_s[i] & sw_on[i] & ~fw_active_i[i];
    if (i < 2) begin : g_led
      assign ol_lim = fwol_reg[i] ? 12'(`HBF_T_OLS_CYC) : 12'(`HBF_T_OL_CYC);
    end else begin : g_std
      assign ol_lim = 12'(`HBF_T_OL_CYC);
    end
    assign oc_set[i]  = oc_cond & (oc_cnt_reg == 12'(`HBF_T_OC_CYC - 1));
    assign ol_set[i]  = ol_cond & (ol_cnt_reg >= ol_lim - 12'h1);
    assign oc_flag[i] = oc_q;
    assign ol_flag[i] = ol_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        oc_cnt_reg <= 12'h0;
        ol_cnt_reg <= 12'h0;
        oc_q       <= 1'b0;
        ol_q       <= 1'b0;
      end else begin
        oc_cnt_reg <= !oc_cond ? 12'h0 : oc_set[i] ? oc_cnt_reg
                                       : oc_cnt_reg + 12'h1;
        ol_cnt_reg <= !ol_cond ? 12'h0 : ol_set[i] ? ol_cnt_reg
                                       : ol_cnt_reg + 12'h1;
        oc_q <= oc_set[i] | (oc_q & ~oc_clr[i]);
        ol_q <= ol_set[i] | (ol_q & ~ol_clr[i]);
      end
    end
  end

  // ========================================================================
  // Bridge drive with dead time; both requested means both off
  for (genvar j = 0; j < 8; j++) begin : g_br
    logic [5:0] dt_reg;
    logic       hs_q, ls_q, req_h, req_l;
    assign req_h = allow[j] & ~allow[j+8];
    assign req_l = allow[j+8] & ~allow[j];
    assign hs_on_o[j] = hs_q;
    assign ls_on_o[j] = ls_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        hs_q   <= 1'b0;
        ls_q   <= 1'b0;
        dt_reg <= 6'h0;
      end else if (hs_q && !req_h) begin
        hs_q   <= 1'b0;
        dt_reg <= 6'(`HBF_DEAD_TIME_HIGH_TO_LOW_CYC);
      end else if (ls_q && !req_l) begin
        ls_q   <= 1'b0;
        dt_reg <= 6'(`HBF_DEAD_TIME_LOW_TO_HIGH_CYC);
      end else if (dt_reg != 6'h0) begin
        dt_reg <= dt_reg - 6'h1;
      end else begin
        hs_q <= req_h;
        ls_q <= req_l;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ol_low_thr_o <= 2'h0;
    end else begin
      ol_low_thr_o <= fwol_reg;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_end;
    state_reg == HBF_SHIFT && csn_rise;
  endsequence

  a_no_cross: assert property ((hs_on_o & ls_on_o) == 8'h0)
    else $error("both sides of a bridge on");
  a_dead_gap: assert property ($fell(hs_on_o[0]) |-> (!ls_on_o[0])[*8])
    else $error("low side on inside dead time");
  a_tsd_off: assert property (tsd_reg |=> (hs_on_o | ls_on_o) == 8'h0)
    else $error("output on during thermal shutdown");
  a_oc_hold: assert property (oc_flag[8] && $past(oc_flag[8]) |-> !ls_on_o[0])
    else $error("switch on with overcurrent flag");
  a_oc_le: assert property ($rose(oc_flag[8]) |-> le_reg)
    else $error("load error not set with overcurrent");
  a_uv_off: assert property (sup_s.uv |=> (hs_on_o | ls_on_o) == 8'h0 && uv_reg)
    else $error("undervoltage did not switch off");
  a_ov_latch: assert property (sup_s.ov ##1 !gclr |=> ov_reg)
    else $error("overvoltage flag not latched");
  a_tpw_hold: assert property (tpw_reg && !gclr |=> tpw_reg)
    else $error("prewarning flag self-cleared");
  a_ol_blank: assert property (fw_active_i[8] |-> !ol_set[8])
    else $error("open load set while free-wheeling");
  a_sdo_free: assert property (s_frame_end |=> !sdo_oe_o)
    else $error("data out not released");
  a_setup_ign: assert property (csn_fall && !set_done |=> state_reg == HBF_IDLE)
    else $error("frame accepted before setup time");
endmodule : hbf_supervisor

// >>> hbf_host.sv
// Host serial master model: clock idle low, MSB first, 320 ns clock.
// Assumes the caller has already waited out the enable setup time.
`timescale 1ns/1ps
module hbf_host (
  output logic      sclk_o,
  output logic      csn_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  // ==========
  // Idle levels
  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    sdi_o  = 1'b0;
  end
  // ==========
  // Frame
  // Clock stands still outside frames; offset keeps it off the system grid
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    #13 csn_o = 1'b0;
    #160;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b1;
      sdi_o  = w[i];
      #160 sclk_o = 1'b0;
      #80 r[i] = sdo_i;
      #80;
    end
    csn_o = 1'b1;
    sdi_o = ~sdi_o;
    #320;
  endtask : xfer
endmodule : hbf_host

// >>> hbf_supervisor_bench.sv
// Bench: host model, reference model of flags and outputs, checks.
// Assumes hbf_host drives the serial pins and a 25 MHz system clock.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end
module hbf_supervisor_bench;
  import hbf_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        en_i = 1'b0;
  hbf_supply_t sup = '0;
  logic [15:0] oc = '0, ol = '0, fw = '0;
  logic [7:0]  hs_on, ls_on, m_hs, m_ls, m_hoc, m_loc, m_hol, m_lol;
  logic [1:0]  thr, m_fw;
  logic        sdo, oe, sclk, csn, sdi, seen;
  logic        le, uv, ov, power_on_reset_negated, thermal_shutdown_flag, thermal_prewarning_flag;
  int          n_errors = 0, comparisons = 0, seed = 32;
  // ==========
  // Clock, instances, monitors
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (oe === 1'b1) seen <= 1'b1;
  always @(negedge clk_sys_i) if (!rst_i) `CHK(hs_on & ls_on, 8'h00)
  hbf_supervisor hbf_supervisor_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sclk_i(sclk), .csn_i(csn), .sdi_i(sdi), .en_i(en_i), .supply_i(sup),
    .oc_raw_i(oc), .ol_raw_i(ol), .fw_active_i(fw), .hs_on_o(hs_on),
    .ls_on_o(ls_on), .ol_low_thr_o(thr), .sdo_o(sdo), .sdo_oe_o(oe));
  // Released data line shows the inverse of the last driven bit
  hbf_host hbf_host_inst (.sclk_o(sclk), .csn_o(csn), .sdi_o(sdi),
    .sdo_i(oe ? sdo : ~sdo));
  // ==========
  // Reference model
  function automatic logic [7:0] rd(input logic [6:0] a);
    case (a)
      7'h00: return m_hs;
      7'h01: return m_ls;
      7'h02: return {6'h00, m_fw};
      7'h10: return {1'b0, le, uv, ov, power_on_reset_negated, thermal_shutdown_flag, thermal_prewarning_flag, 1'b0};
      7'h11: return m_hoc;
      7'h12: return m_loc;
      7'h13: return m_hol;
      7'h14: return m_lol;
      default: return 8'h00;
    endcase
  endfunction : rd
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : wt
  task automatic sf(input int k);
    case (k)
      0: thermal_prewarning_flag = 1'b1;
      1: thermal_shutdown_flag = 1'b1;
      2: uv = 1'b1;
      default: ov = 1'b1;
    endcase
  endtask : sf
  // One whole frame; expectation taken before the frame acts
  task automatic xf(input logic op, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r, e;
    e = {rd(7'h10), rd(a)};
    @(negedge clk_sys_i);
    seen = 1'b0;
    hbf_host_inst.xfer({op, a, d}, r);
    `CHK(r, e)
    `CHK(seen, 1'b1)
    `CHK(oe, 1'b0)
    if (op) begin
      case (a)
        7'h00: m_hs = d;
        7'h01: m_ls = d;
        7'h02: m_fw = d[1:0];
        7'h10: begin
          {le, uv, ov, thermal_shutdown_flag, thermal_prewarning_flag} = '0;
          power_on_reset_negated = 1'b1;
        end
        7'h11: m_hoc = '0;
        7'h12: m_loc = '0;
        7'h13: m_hol = '0;
        7'h14: m_lol = '0;
        default: ;
      endcase
    end
    wt(10);
  endtask : xf
  // Dead time and synchronisers settle well inside 80 cycles; filter waits are the caller's
  task automatic chk_out();
    logic off;
    wt(80);
    off = thermal_shutdown_flag | sup.sd | sup.uv | sup.ov;
    `CHK(hs_on, m_hs & ~m_ls & ~m_hoc & {8{~off}})
    `CHK(ls_on, m_ls & ~m_hs & ~m_loc & {8{~off}})
  endtask : chk_out
  task automatic conclude();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    #2_000_000;
    n_errors++;
    conclude();
  end
  // ==========
  // Tests
  initial begin
    logic [15:0] r;
    {m_hs, m_ls, m_hoc, m_loc, m_hol, m_lol, m_fw} = '0;
    {le, uv, ov, power_on_reset_negated, thermal_shutdown_flag, thermal_prewarning_flag} = '0;
    wt(2);
    `CHK({hs_on, ls_on, oe}, 17'h0)
    rst_i = 1'b0;
    seen = 1'b0;
    hbf_host_inst.xfer(16'h80ff, r);
    en_i = 1'b1;
    hbf_host_inst.xfer(16'h80ff, r);
    `CHK(seen, 1'b0)
    wt(300);
    chk_out();
    xf(1'b0, 7'h10, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      xf(1'b1, 7'h00, 8'($random(seed)));
      chk_out();
      xf(1'b0, 7'h00, 8'h00);
      xf(1'b0, 7'h20 | 7'($random(seed)), 8'h00);
    end
    xf(1'b1, 7'h00, 8'h00);
    xf(1'b1, 7'h01, 8'h01);
    chk_out();
    $display("test enable done");
    oc[8] = 1'b1;
    wt(100);
    oc[8] = 1'b0;
    chk_out();
    xf(1'b0, 7'h12, 8'h00);
    oc[8] = 1'b1;
    wt(140);
    m_loc[0] = 1'b1;
    le = 1'b1;
    chk_out();
    xf(1'b0, 7'h01, 8'h00);
    xf(1'b1, 7'h12, 8'h00);
    wt(200);
    m_loc[0] = 1'b1;
    chk_out();
    oc[8] = 1'b0;
    xf(1'b1, 7'h12, 8'h00);
    chk_out();
    $display("test overcurrent done");
    fw[8] = 1'b1;
    ol[8] = 1'b1;
    wt(2600);
    xf(1'b0, 7'h14, 8'h00);
    fw[8] = 1'b0;
    wt(2600);
    m_lol[0] = 1'b1;
    chk_out();
    ol[8] = 1'b0;
    xf(1'b1, 7'h14, 8'h00);
    xf(1'b1, 7'h02, 8'h01);
    `CHK(thr, 2'b01)
    xf(1'b1, 7'h01, 8'h00);
    xf(1'b1, 7'h00, 8'h01);
    ol[0] = 1'b1;
    wt(600);
    m_hol[0] = 1'b1;
    xf(1'b0, 7'h13, 8'h00);
    ol[0] = 1'b0;
    $display("test open load done");
    for (int k = 0; k < 4; k++) begin
      sup = hbf_supply_t'(4'h8 >> k);
      wt(10);
      sf(k);
      chk_out();
      xf(1'b1, 7'h10, 8'h00);
      sf(k);
      xf(1'b0, 7'h10, 8'h00);
      sup = '0;
      chk_out();
      xf(1'b0, 7'h10, 8'h00);
      xf(1'b1, 7'h10, 8'h00);
      chk_out();
    end
    $display("test supply done");
    rst_i = 1'b1;
    wt(2);
    `CHK({hs_on, ls_on, oe}, 17'h0)
    rst_i = 1'b0;
    {m_hs, m_ls, m_hoc, m_loc, m_hol, m_lol, m_fw} = '0;
    {le, uv, ov, power_on_reset_negated, thermal_shutdown_flag, thermal_prewarning_flag} = '0;
    chk_out();
    wt(300);
    xf(1'b0, 7'h10, 8'h00);
    $display("test second reset done");
    conclude();
  end
endmodule : hbf_supervisor_bench
